// >>> src/safety_cfg_and_diag_probe_mux.sv
`timescale 1ns/100ps
`include "safety_probe_consts.svh"

module safety_cfg_and_diag_probe_mux
  import safety_probe_pkg::*;
#(
  parameter logic [15:0] STEP_CYCLES = 16'(`LOW_STEP_CYCLES)
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Device state and lock bits
  input wire logic resetStateEntry,
  input wire logic inSelfCheck,
  input wire logic configLock,
  input wire logic controlLock,
  // Serial command port
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdSelect,
  input wire logic [7:0] cmdWriteData,
  output logic [7:0] cmdReadData,
  output logic cmdWriteRefused,
  // Error monitor
  input wire logic error_monitor_pwm_select,
  input wire logic errorInput,
  output logic lowPhaseTooShort,
  // Shutdown path
  input wire logic [3:0] device_error_counter,
  output logic shutdownRequest,
  // Checksum reference
  output logic [7:0] expected_config_checksum,
  // Pins seen for interconnect test
  input wire logic serial_select_n,
  input wire logic serialDataIn,
  input wire logic serialClock,
  input wire logic serialOutFunctional,
  input wire logic serialOutFunctionalOe,
  output logic serialOut,
  output logic serialOutOe,
  // Digital and analog probe sources
  input wire logic [31:0] digitalProbes,
  output logic analogMuxEnable,
  output logic [7:0] analogChannel,
  // Probe output pin
  output logic probe_output_pin,
  output logic probeOutputOe
);

  reg_byte_type lowMin_q; // Low-phase minimum field
  logic shutdownEnable_q; // Shutdown on threshold
  logic [3:0] shutdownTh_q; // Error count threshold
  reg_byte_type checksum_q; // Expected checksum
  reg_byte_type probeCtrl_q; // Probe control
  reg_byte_type channel_q; // Probe channel select
  logic cfgWriteOk; // Safety config write allowed
  logic ctrlWriteOk; // Probe control write allowed
  logic isWrite; // Command is a write
  logic refused; // Write hit a locked register
  mux_mode_type muxMode; // Decoded mux mode
  logic [2:0] iconSel; // Interconnect select
  logic outEnable; // Probe output enable bit
  logic probeLevel; // Level for the probe pin

  assign isWrite = cmdValid && cmdWrite;
  assign cfgWriteOk = inSelfCheck && !configLock;
  assign ctrlWriteOk = !controlLock;
  assign muxMode = mux_mode_type'(probeCtrl_q[`PC_CFG_HI:`PC_CFG_LO]);
  assign iconSel = probeCtrl_q[`PC_ICON_HI:`PC_ICON_LO];
  assign outEnable = probeCtrl_q[`PC_OUT_EN];

  // Safety config: power-on reset only, never device RESET
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowMin_q <= `RST_LOW_MIN;
      shutdownEnable_q <= `RST_SHUTDOWN_EN;
      shutdownTh_q <= `RST_SHUTDOWN_TH;
      checksum_q <= `RST_CHECKSUM;
    end else if (isWrite && cfgWriteOk) begin
      if (cmdSelect == `SEL_LOW_MIN) begin
        lowMin_q <= cmdWriteData;
      end else if (cmdSelect == `SEL_SHUTDOWN_TH) begin
        // Reserved bits 7:5 are dropped
        shutdownEnable_q <= cmdWriteData[`TH_ENABLE];
        shutdownTh_q <= cmdWriteData[`TH_FIELD_HI:0];
      end else if (cmdSelect == `SEL_CHECKSUM) begin
        checksum_q <= cmdWriteData;
      end
    end
  end

  // Probe control: cleared on power-on and on RESET state entry
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      probeCtrl_q <= `RST_PROBE_CTRL;
    end else if (resetStateEntry) begin
      probeCtrl_q <= `RST_PROBE_CTRL;
    end else if (isWrite && ctrlWriteOk && cmdSelect == `SEL_PROBE_CTRL) begin
      probeCtrl_q <= cmdWriteData;
    end
  end

  // Channel select: free to write, same reset sources
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_q <= `RST_CHANNEL;
    end else if (resetStateEntry) begin
      channel_q <= `RST_CHANNEL;
    end else if (isWrite && cmdSelect == `SEL_CHANNEL) begin
      channel_q <= cmdWriteData;
    end
  end

  // Refused-write flag, one cycle after the command
  always_comb begin
    refused = 1'b0;
    if (!isWrite) begin
      refused = 1'b0;
    end else if (cmdSelect == `SEL_LOW_MIN || cmdSelect == `SEL_SHUTDOWN_TH || cmdSelect == `SEL_CHECKSUM) begin
      refused = !cfgWriteOk;
    end else if (cmdSelect == `SEL_PROBE_CTRL) begin
      refused = !ctrlWriteOk;
    end
  end

  // Read data registered; unknown selects read zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdReadData <= 8'h00;
      cmdWriteRefused <= 1'b0;
    end else begin
      cmdWriteRefused <= refused;
      if (cmdValid && !cmdWrite) begin
        if (cmdSelect == `SEL_LOW_MIN) begin
          cmdReadData <= lowMin_q;
        end else if (cmdSelect == `SEL_SHUTDOWN_TH) begin
          cmdReadData <= {3'h0, shutdownEnable_q, shutdownTh_q};
        end else if (cmdSelect == `SEL_CHECKSUM) begin
          cmdReadData <= checksum_q;
        end else if (cmdSelect == `SEL_PROBE_CTRL) begin
          cmdReadData <= probeCtrl_q;
        end else if (cmdSelect == `SEL_CHANNEL) begin
          cmdReadData <= channel_q;
        end else begin
          cmdReadData <= 8'h00;
        end
      end
    end
  end

  // Shutdown request; registered so it is glitch free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdownRequest <= 1'b0;
    end else begin
      shutdownRequest <= shutdownEnable_q && (device_error_counter == shutdownTh_q);
    end
  end

  assign expected_config_checksum = checksum_q;

  // Probe pin level per mode
  always_comb begin
    probeLevel = 1'b0;
    case (muxMode)
      MUX_FORCED: probeLevel = probeCtrl_q[`PC_FORCED_LEVEL];
      MUX_DIGITAL: begin
        // Channel only counts while no interconnect code is set
        if (iconSel == `ICON_NONE) begin
          probeLevel = digitalProbes[channel_q[4:0]];
        end
      end
      MUX_ANALOG: probeLevel = 1'b0;
      MUX_INTERCONNECT: begin
        // Unused codes and 000b give a low level
        if (iconSel == `ICON_ERROR) begin
          probeLevel = errorInput;
        end else if (iconSel == `ICON_SELECT) begin
          probeLevel = serial_select_n;
        end else if (iconSel == `ICON_SDI) begin
          probeLevel = serialDataIn;
        end else if (iconSel == `ICON_SCK) begin
          probeLevel = serialClock;
        end else if (iconSel == `ICON_SDO) begin
          probeLevel = serialOut;
        end
      end
      default: probeLevel = 1'b0;
    endcase
  end

  // Analog path owns the pin in analog mode with no interconnect code set; digital driver stays off in analog mode
  assign analogMuxEnable = outEnable && (muxMode == MUX_ANALOG) && (iconSel == `ICON_NONE);
  assign analogChannel = channel_q;

  // Probe pin driver from flops, tri-stated while disabled
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      probe_output_pin <= 1'b0;
      probeOutputOe <= 1'b0;
    end else begin
      probe_output_pin <= probeLevel;
      probeOutputOe <= outEnable && (muxMode != MUX_ANALOG);
    end
  end

  // Serial out override; functional path otherwise
  always_comb begin
    serialOut = serialOutFunctional;
    serialOutOe = serialOutFunctionalOe;
    if (outEnable && iconSel == `ICON_SDO && muxMode == MUX_INTERCONNECT && serial_select_n) begin
      serialOut = probeCtrl_q[`PC_SDO_LEVEL];
      serialOutOe = 1'b1;
    end
  end

  // Low-phase minimum checker
  low_phase_monitor #(
    .STEP_CYCLES(STEP_CYCLES)
  ) lowMonitor (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pwmMode(error_monitor_pwm_select),
    .lowPhaseMinLimit(lowMin_q),
    .errorInput(errorInput),
    .lowPhaseTooShort(lowPhaseTooShort)
  );

endmodule

// >>> src/safety_probe_consts.svh
`ifndef SAFETY_PROBE_CONSTS_SVH
`define SAFETY_PROBE_CONSTS_SVH

// Register select codes on the command port
`define SEL_LOW_MIN 3'h0
`define SEL_SHUTDOWN_TH 3'h1
`define SEL_CHECKSUM 3'h2
`define SEL_PROBE_CTRL 3'h3
`define SEL_CHANNEL 3'h4

// Reset values
`define RST_LOW_MIN 8'h3C
`define RST_SHUTDOWN_EN 1'h0
`define RST_SHUTDOWN_TH 4'hF
`define RST_CHECKSUM 8'h96
`define RST_PROBE_CTRL 8'h00
`define RST_CHANNEL 8'h00

// Probe control field positions
`define PC_OUT_EN 7
`define PC_SDO_LEVEL 6
`define PC_FORCED_LEVEL 5
`define PC_ICON_HI 4
`define PC_ICON_LO 2
`define PC_CFG_HI 1
`define PC_CFG_LO 0

// Shutdown threshold register fields
`define TH_ENABLE 4
`define TH_FIELD_HI 3

// Interconnect codes
`define ICON_NONE 3'h0
`define ICON_ERROR 3'h1
`define ICON_SELECT 3'h2
`define ICON_SDI 3'h3
`define ICON_SCK 3'h4
`define ICON_SDO 3'h7

// Timing: low-phase step of 15 us at a 100 ns clock
`define LOW_STEP_NS 15000
`define CLK_PERIOD_NS 100
`define LOW_STEP_CYCLES (`LOW_STEP_NS / `CLK_PERIOD_NS)

`endif

// >>> src/safety_probe_pkg.sv
package safety_probe_pkg;
  // Byte-wide register value
  typedef logic [7:0] reg_byte_type;
  // Mux configuration modes, in field order 00b..11b
  typedef enum logic [1:0] {
    MUX_FORCED,
    MUX_DIGITAL,
    MUX_ANALOG,
    MUX_INTERCONNECT
  } mux_mode_type;
  // Low-phase monitor states
  typedef enum logic {
    MON_HIGH,
    MON_LOW
  } monitor_state_type;
endpackage

// >>> src/low_phase_monitor.sv
`timescale 1ns/100ps
`include "safety_probe_consts.svh"

module low_phase_monitor
  import safety_probe_pkg::*;
#(
  parameter logic [15:0] STEP_CYCLES = 16'(`LOW_STEP_CYCLES)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic pwmMode,
  input wire logic [7:0] lowPhaseMinLimit,
  // Monitored input
  input wire logic errorInput,
  // Result
  output logic lowPhaseTooShort
);

  monitor_state_type state_q;
  logic [15:0] lowCount_q; // Cycles spent low, saturating
  logic [15:0] minCycles; // (field + 1) x step

  // Minimum low time in cycles
  assign minCycles = 16'(({8'h00, lowPhaseMinLimit} + 16'h0001) * STEP_CYCLES);

  // Phase tracking; only PWM mode checks the low minimum
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= MON_HIGH;
      lowCount_q <= 16'h0000;
      lowPhaseTooShort <= 1'b0;
    end else begin
      lowPhaseTooShort <= 1'b0;
      case (state_q)
        MON_HIGH: begin
          // Start counting on the falling edge
          if (pwmMode && !errorInput) begin
            state_q <= MON_LOW;
            lowCount_q <= 16'h0001;
          end
        end
        MON_LOW: begin
          if (!pwmMode) begin
            // Low-pulse mode does not use this limit
            state_q <= MON_HIGH;
          end else if (errorInput) begin
            // Rising edge ends the low phase
            state_q <= MON_HIGH;
            lowPhaseTooShort <= (lowCount_q < minCycles);
          end else if (lowCount_q != 16'hFFFF) begin
            lowCount_q <= lowCount_q + 16'h0001;
          end
        end
        default: state_q <= MON_HIGH;
      endcase
    end
  end

endmodule

// >>> verif/safety_probe_assertions.sv
`timescale 1ns/100ps
// Port-level checks of locks, probe pin and reset entry
module safety_probe_assertions #(
  parameter logic [15:0] STEP_CYCLES = 16'h0096
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Inputs
  input wire logic resetStateEntry,
  input wire logic inSelfCheck,
  input wire logic configLock,
  input wire logic controlLock,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdSelect,
  input wire logic [7:0] cmdWriteData,
  input wire logic error_monitor_pwm_select,
  // Outputs
  input wire logic [7:0] cmdReadData,
  input wire logic cmdWriteRefused,
  input wire logic lowPhaseTooShort,
  input wire logic analogMuxEnable,
  input wire logic [7:0] analogChannel,
  input wire logic probe_output_pin,
  input wire logic probeOutputOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Probe control write that is let through; a RESET entry beats it
  logic ctrlWr;
  assign ctrlWr = cmdValid && cmdWrite && cmdSelect == 3'h3 && !controlLock && !resetStateEntry;
  a_cfg_refuse:
    assert property (cmdValid && cmdWrite && cmdSelect <= 3'h2 && !(inSelfCheck && !configLock) |=> cmdWriteRefused)
    else $error("locked config write not refused");
  a_cfg_accept:
    assert property (cmdValid && cmdWrite && cmdSelect <= 3'h2 && inSelfCheck && !configLock |=> !cmdWriteRefused)
    else $error("open config write refused");
  a_ctrl_refuse:
    assert property (cmdValid && cmdWrite && cmdSelect == 3'h3 && controlLock |=> cmdWriteRefused)
    else $error("locked control write not refused");
  a_pin_float:
    assert property ((ctrlWr && !cmdWriteData[7]) || resetStateEntry |=> ##1 !probeOutputOe)
    else $error("probe pin driven while disabled");
  a_forced_level:
    assert property (ctrlWr && cmdWriteData[7] && cmdWriteData[1:0] == 2'h0 ##1 !resetStateEntry
      |=> probeOutputOe && probe_output_pin == $past(cmdWriteData[5], 2))
    else $error("forced level wrong");
  a_reset_clear:
    assert property (resetStateEntry |=> !analogMuxEnable && analogChannel == 8'h00)
    else $error("reset entry left probe setup");
  a_rsvd_read:
    assert property (cmdValid && !cmdWrite && cmdSelect == 3'h1 |=> cmdReadData[7:5] == 3'h0)
    else $error("reserved threshold bits set");
  a_lowpulse_quiet:
    assert property (!error_monitor_pwm_select ##1 !error_monitor_pwm_select |-> !lowPhaseTooShort)
    else $error("pulse outside pwm mode");
endmodule

bind safety_cfg_and_diag_probe_mux safety_probe_assertions #(.STEP_CYCLES(STEP_CYCLES)) i_safety_probe_assertions (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .resetStateEntry(resetStateEntry), .inSelfCheck(inSelfCheck),
  .configLock(configLock), .controlLock(controlLock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
  .cmdSelect(cmdSelect), .cmdWriteData(cmdWriteData), .error_monitor_pwm_select(error_monitor_pwm_select),
  .cmdReadData(cmdReadData), .cmdWriteRefused(cmdWriteRefused), .lowPhaseTooShort(lowPhaseTooShort),
  .analogMuxEnable(analogMuxEnable), .analogChannel(analogChannel), .probe_output_pin(probe_output_pin),
  .probeOutputOe(probeOutputOe)
);

// >>> verif/host_serial_model.sv
`timescale 1ns/100ps
// Host side of the command port: one-cycle strobe per bench request
module host_serial_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bench requests
  input wire logic reqGo,
  input wire logic reqWrite,
  input wire logic [2:0] reqSelect,
  input wire logic [7:0] reqData,
  // Command port
  output logic cmdValid,
  output logic cmdWrite,
  output logic [2:0] cmdSelect,
  output logic [7:0] cmdWriteData
);
  // Idle fields toggle so a stale value never looks like a command
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdValid <= 1'b0;
      cmdWrite <= 1'b0;
      cmdSelect <= 3'h0;
      cmdWriteData <= 8'h00;
    end else begin
      cmdValid <= reqGo;
      cmdWrite <= reqGo ? reqWrite : ~cmdWrite;
      cmdSelect <= reqGo ? reqSelect : ~cmdSelect;
      cmdWriteData <= reqGo ? reqData : ~cmdWriteData;
    end
  end
endmodule

// >>> verif/test_safety_cfg_and_diag_probe_mux.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
// Random register traffic through the host model, pins checked by the bench
module test_safety_cfg_and_diag_probe_mux;
  logic ref_clk = 0, sys_rst = 1, resetStateEntry = 0, inSelfCheck = 0, configLock = 0, controlLock = 0;
  logic cmdValid, cmdWrite, reqGo = 0, reqWrite = 0, error_monitor_pwm_select = 0, errorInput = 1;
  logic serial_select_n = 1, serialDataIn = 0, serialClock = 0, serialOutFunctional = 0, serialOutFunctionalOe = 0;
  logic cmdWriteRefused, lowPhaseTooShort, shutdownRequest, serialOut, serialOutOe, analogMuxEnable;
  logic probe_output_pin, probeOutputOe;
  logic [2:0] cmdSelect, reqSelect = 0;
  logic [3:0] device_error_counter = 0, r;
  logic [7:0] cmdWriteData, reqData = 0, cmdReadData, analogChannel, expected_config_checksum;
  logic [31:0] digitalProbes = 0;
  logic [7:0] regExp [8] = '{8'h3C, 8'h0F, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_fail = 0, checks = 0, cyc = 0, pulses = 0;

  // Short step keeps the low-phase tests brief
  safety_cfg_and_diag_probe_mux #(.STEP_CYCLES(16'h0002)) i_safety_cfg_and_diag_probe_mux (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .resetStateEntry(resetStateEntry), .inSelfCheck(inSelfCheck),
    .configLock(configLock), .controlLock(controlLock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdSelect(cmdSelect), .cmdWriteData(cmdWriteData), .cmdReadData(cmdReadData),
    .cmdWriteRefused(cmdWriteRefused), .error_monitor_pwm_select(error_monitor_pwm_select),
    .errorInput(errorInput), .lowPhaseTooShort(lowPhaseTooShort), .device_error_counter(device_error_counter),
    .shutdownRequest(shutdownRequest), .expected_config_checksum(expected_config_checksum),
    .serial_select_n(serial_select_n), .serialDataIn(serialDataIn), .serialClock(serialClock),
    .serialOutFunctional(serialOutFunctional), .serialOutFunctionalOe(serialOutFunctionalOe),
    .serialOut(serialOut), .serialOutOe(serialOutOe), .digitalProbes(digitalProbes),
    .analogMuxEnable(analogMuxEnable), .analogChannel(analogChannel), .probe_output_pin(probe_output_pin),
    .probeOutputOe(probeOutputOe)
  );
  host_serial_model i_host_serial_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reqGo(reqGo), .reqWrite(reqWrite), .reqSelect(reqSelect),
    .reqData(reqData), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdSelect(cmdSelect),
    .cmdWriteData(cmdWriteData)
  );

  always #50 ref_clk = ~ref_clk;
  // Pulses are counted away from the edge
  always @(negedge ref_clk) if (lowPhaseTooShort === 1'b1) pulses++;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Returns once the command's effect has reached the pins
  task automatic cmd(input logic w, input logic [2:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    reqGo <= 1'b1;
    reqWrite <= w;
    reqSelect <= s;
    reqData <= d;
    @(posedge ref_clk);
    reqGo <= 1'b0;
    tick(2);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    cmd(1'b1, s, d);
    if (s == 3'h4 || (s == 3'h3 && !controlLock) || (s < 3'h3 && inSelfCheck && !configLock))
      regExp[s] = (s == 3'h1) ? (d & 8'h1F) : d;
  endtask
  task automatic rd(input logic [2:0] s);
    cmd(1'b0, s, 8'h00);
    `CHK("read", regExp[s], cmdReadData)
  endtask
  // Level expected on the probe pin per interconnect code
  function automatic logic icon(input int c);
    case (c)
      1: return errorInput;
      2: return serial_select_n;
      3: return serialDataIn;
      4: return serialClock;
      7: return serial_select_n ? 1'b1 : serialOutFunctional;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    void'($urandom(32'h164F5945));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 8; s++) rd(3'(s));
    for (int i = 0; i < 64; i++) begin
      inSelfCheck <= i[3];
      configLock <= i[4];
      controlLock <= i[5];
      wr(3'(i), 8'($urandom));
      rd(3'(i));
    end
    inSelfCheck <= 1'b1;
    configLock <= 1'b0;
    controlLock <= 1'b0;
    wr(3'h2, 8'($urandom));
    `CHK("checksum", regExp[2], expected_config_checksum)
    for (int i = 0; i < 16; i++) begin
      wr(3'h1, 8'($urandom));
      device_error_counter <= i[0] ? regExp[1][3:0] : 4'($urandom);
      tick(1);
      `CHK("shutdown", regExp[1][4] && device_error_counter == regExp[1][3:0], shutdownRequest)
    end
    for (int i = 0; i < 4; i++) begin
      wr(3'h3, {i[1], 1'b0, i[0], 5'h00});
      `CHK("oe", i[1], probeOutputOe)
      if (i[1]) `CHK("pin", i[0], probe_output_pin)
    end
    for (int c = 0; c < 8; c++) begin
      r = 4'($urandom);
      errorInput <= r[0];
      serial_select_n <= r[1] | (c == 7);
      serialDataIn <= r[2];
      serialClock <= r[3];
      serialOutFunctional <= 1'($urandom);
      serialOutFunctionalOe <= 1'($urandom);
      wr(3'h3, {3'b110, 3'(c), 2'b11});
      `CHK("icon", icon(c), probe_output_pin)
      if (c == 7) `CHK("sdo", 2'b11, {serialOut, serialOutOe})
      else `CHK("sdo pass", {serialOutFunctional, serialOutFunctionalOe}, {serialOut, serialOutOe})
    end
    digitalProbes <= $urandom;
    wr(3'h4, 8'($urandom));
    wr(3'h3, 8'h81);
    `CHK("digital", digitalProbes[regExp[4][4:0]], probe_output_pin)
    // Interconnect code set in digital mode: channel ignored, pin low
    wr(3'h3, 8'h85);
    `CHK("digital icon", 2'b10, {probeOutputOe, probe_output_pin})
    wr(3'h3, 8'h82);
    `CHK("analog", {1'b1, 1'b0, regExp[4]}, {analogMuxEnable, probeOutputOe, analogChannel})
    wr(3'h3, 8'h8E);
    `CHK("analog off", 1'b0, analogMuxEnable)
    resetStateEntry <= 1'b1;
    tick(1);
    resetStateEntry <= 1'b0;
    regExp[3] = 8'h00;
    regExp[4] = 8'h00;
    for (int s = 0; s < 5; s++) rd(3'(s));
    wr(3'h0, 8'h01);
    for (int k = 0; k < 3; k++) begin
      error_monitor_pwm_select <= (k < 2);
      errorInput <= 1'b1;
      tick(2);
      pulses = 0;
      errorInput <= 1'b0;
      tick(3 + k % 2);
      errorInput <= 1'b1;
      tick(4);
      `CHK("pulses", int'(k == 0), pulses)
    end
    test_done();
  end
endmodule
